// file: logic/cic_defines.vh
// register locations, field positions and fixed counts of the capture timer
// assumes: included by bare name from every design file of the timer
`ifndef CIC_DEFINES_VH
`define CIC_DEFINES_VH

// =====
// i/o locations (4-bit address)
`define CIC_A_CTRL_A 4'h0
`define CIC_A_CTRL_B 4'h1
`define CIC_A_CNT_LO 4'h2
`define CIC_A_CNT_HI 4'h3
`define CIC_A_CAP_LO 4'h4
`define CIC_A_CAP_HI 4'h5
`define CIC_A_CMPA_LO 4'h6
`define CIC_A_CMPA_HI 4'h7
`define CIC_A_FLAGS 4'h8
`define CIC_A_MASK 4'h9
`define CIC_A_COMP 4'hA

// =====
// field positions
`define CIC_B_FILTER 7
`define CIC_B_EDGE 6
`define CIC_B_WGM_HI 4
`define CIC_B_WGM_LO 3
`define CIC_B_CS_HI 2
`define CIC_B_CS_LO 0
`define CIC_F_OVF 0
`define CIC_F_CAP 5
`define CIC_C_SRC 2

// =====
// reset values and fixed counts
`define CIC_RST_BYTE 8'h00
`define CIC_RST_WORD 16'h0000
`define CIC_BOTTOM 16'h0000
`define CIC_MAX 16'hFFFF
`define CIC_TOP_8 16'h00FF
`define CIC_TOP_9 16'h01FF
`define CIC_TOP_10 16'h03FF
`define CIC_FILTER_LEN 4

`endif

// file: logic/cic_filter.v
// noise filter on the synchronised trigger: output follows input one cycle later,
// or, when enabled, only after four agreeing samples (four cycles later than the bypass)
// assumes: din already passed a two-stage synchroniser on clk
`include "cic_defines.vh"
`default_nettype none

module cic_filter (
    input wire clk, // system clock
    input wire reset, // async reset, active high
    input wire enable, // filter on
    input wire din, // synchronised trigger
    output reg dout // filtered trigger
);

    // =====
    // sample history
    reg [`CIC_FILTER_LEN-1:0] hist_r; // last four samples, newest in bit 0

    // shift in every system clock, prescaler plays no part
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            hist_r <= {`CIC_FILTER_LEN{1'b0}};
        end else begin
            hist_r <= {hist_r[`CIC_FILTER_LEN-2:0], din};
        end
    end

    // =====
    // output: when enabled, change only when all four samples agree
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            dout <= 1'b0;
        end else if (!enable) begin
            dout <= din; // bypass, one cycle
        end else if (&hist_r) begin
            dout <= 1'b1;
        end else if (~|hist_r) begin
            dout <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// file: logic/cic_timer.v
// 16-bit up/down counter with input capture, byte-wide i/o locations
// assumes: one 20 MHz clk; prescale_tick is a same-domain one-cycle pulse;
// capture_pin and comparator_output are asynchronous levels
`include "cic_defines.vh"
`default_nettype none

module cic_timer (
    input wire clk, // 20 MHz system clock
    input wire reset, // async reset, active high
    input wire [3:0] io_addr, // i/o location
    input wire io_wr, // write strobe, one cycle
    input wire io_rd, // read strobe, one cycle
    input wire [7:0] io_wdata, // write data
    output reg [7:0] io_rdata, // read data, valid the cycle after io_rd
    input wire prescale_tick, // tick from the prescaler, one cycle
    input wire capture_pin, // capture pin level (includes own port drive)
    input wire comparator_output, // comparator output level
    input wire irq_ack_capture, // capture interrupt serviced, pulse
    input wire irq_ack_overflow, // overflow interrupt serviced, pulse
    output wire irq_capture, // capture interrupt request
    output wire irq_overflow, // overflow interrupt request
    output reg [15:0] counter_value // live count
);

    // =====
    // software-visible state
    reg [7:0] control_reg_a; // mode low bits in [1:0]
    reg [7:0] control_reg_b; // filter, edge, mode high, clock select
    reg [7:0] comparator_ctrl_status; // comparator capture select
    reg [15:0] capture_value; // captured count or top
    reg [15:0] compare_a_value; // compare a, used as top
    reg [7:0] temp_r; // shared high-byte latch
    reg overflow_flag; // sticky overflow
    reg capture_flag; // sticky capture
    reg overflow_irq_enable; // overflow request enable
    reg capture_irq_enable; // capture request enable
    reg dir_down_r; // counting down in dual-slope modes

    // =====
    // decoded controls
    wire [3:0] waveform_mode_field; // four-bit mode
    wire [2:0] clock_select_field; // tick selection
    wire timer_tick; // qualified tick
    wire noise_filter_enable; // filter on
    wire edge_rising; // 1: rising edge captures
    wire comparator_capture_select; // trigger from comparator

    // mode field spans both control registers
    assign waveform_mode_field = {control_reg_b[`CIC_B_WGM_HI:`CIC_B_WGM_LO], control_reg_a[1:0]};
    assign clock_select_field = control_reg_b[`CIC_B_CS_HI:`CIC_B_CS_LO];
    // no ticks while clock select is zero
    assign timer_tick = prescale_tick && (clock_select_field != 3'h0);
    assign noise_filter_enable = control_reg_b[`CIC_B_FILTER];
    assign edge_rising = control_reg_b[`CIC_B_EDGE];
    assign comparator_capture_select = comparator_ctrl_status[`CIC_C_SRC];

    // =====
    // mode properties
    reg [15:0] top_value; // current top
    reg mode_dual; // up then down
    reg mode_wrap_top; // single slope, restart at top
    reg mode_clear_top; // clear at top, overflow at max
    reg mode_top_cap; // capture register is top

    // decode counting sequence and top from the mode
    always @* begin
        top_value = `CIC_MAX;
        mode_dual = 1'b0;
        mode_wrap_top = 1'b0;
        mode_clear_top = 1'b0;
        mode_top_cap = 1'b0;
        case (waveform_mode_field)
            4'h1: begin
                top_value = `CIC_TOP_8;
                mode_dual = 1'b1;
            end
            4'h2: begin
                top_value = `CIC_TOP_9;
                mode_dual = 1'b1;
            end
            4'h3: begin
                top_value = `CIC_TOP_10;
                mode_dual = 1'b1;
            end
            4'h4: begin
                top_value = compare_a_value;
                mode_clear_top = 1'b1;
            end
            4'h5: begin
                top_value = `CIC_TOP_8;
                mode_wrap_top = 1'b1;
            end
            4'h6: begin
                top_value = `CIC_TOP_9;
                mode_wrap_top = 1'b1;
            end
            4'h7: begin
                top_value = `CIC_TOP_10;
                mode_wrap_top = 1'b1;
            end
            4'h8, 4'hA: begin
                top_value = capture_value;
                mode_dual = 1'b1;
                mode_top_cap = 1'b1;
            end
            4'h9, 4'hB: begin
                top_value = compare_a_value;
                mode_dual = 1'b1;
            end
            4'hC: begin
                top_value = capture_value;
                mode_clear_top = 1'b1;
                mode_top_cap = 1'b1;
            end
            4'hE: begin
                top_value = capture_value;
                mode_wrap_top = 1'b1;
                mode_top_cap = 1'b1;
            end
            4'hF: begin
                top_value = compare_a_value;
                mode_wrap_top = 1'b1;
            end
            default: begin
                top_value = `CIC_MAX; // normal count, reserved code too
            end
        endcase
    end

    // =====
    // trigger path: synchronise, select, filter, edge detect
    reg pin_s1_r; // pin sync stage 1
    reg pin_s2_r; // pin sync stage 2
    reg cmp_s1_r; // comparator sync stage 1
    reg cmp_s2_r; // comparator sync stage 2
    reg filt_prev_r; // filtered trigger, one cycle old
    wire trig_sel; // selected trigger
    wire trig_filt; // filtered trigger
    wire capture_event; // qualified edge

    // two-stage synchronisers on both trigger inputs
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            pin_s1_r <= 1'b0;
            pin_s2_r <= 1'b0;
            cmp_s1_r <= 1'b0;
            cmp_s2_r <= 1'b0;
        end else begin
            pin_s1_r <= capture_pin; // pin level includes our own drive
            pin_s2_r <= pin_s1_r;
            cmp_s1_r <= comparator_output;
            cmp_s2_r <= cmp_s1_r;
        end
    end

    // source mux; a switch can itself look like an edge
    assign trig_sel = comparator_capture_select ? cmp_s2_r : pin_s2_r;

    cic_filter u_filter (
        .clk(clk),
        .reset(reset),
        .enable(noise_filter_enable),
        .din(trig_sel),
        .dout(trig_filt)
    );

    // edge detector runs on the filtered trigger
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            filt_prev_r <= 1'b0;
        end else begin
            filt_prev_r <= trig_filt;
        end
    end

    // edge polarity chosen by software, blocked in capture-top modes
    assign capture_event = (trig_filt != filt_prev_r) && (trig_filt == edge_rising) && !mode_top_cap;

    // =====
    // access decode
    wire wr_cnt_lo; // counter low write
    wire wr_cap_lo; // capture low write
    wire wr_any_hi; // any high-byte write
    assign wr_cnt_lo = io_wr && (io_addr == `CIC_A_CNT_LO);
    // capture register only writable while it sets the top
    assign wr_cap_lo = io_wr && (io_addr == `CIC_A_CAP_LO) && mode_top_cap;
    assign wr_any_hi = io_wr && ((io_addr == `CIC_A_CNT_HI) || (io_addr == `CIC_A_CAP_HI) ||
                                 (io_addr == `CIC_A_CMPA_HI));

    // =====
    // counter next value
    reg [15:0] cnt_nxt; // count after this tick
    reg dir_nxt; // direction after this tick
    reg ovf_hit; // overflow point reached

    // clear, step up or step down per mode
    always @* begin
        cnt_nxt = counter_value;
        dir_nxt = dir_down_r;
        ovf_hit = 1'b0;
        if (mode_dual) begin
            if (!dir_down_r) begin
                if (counter_value >= top_value) begin
                    dir_nxt = 1'b1; // turn at top
                    cnt_nxt = counter_value - 16'h0001;
                end else begin
                    cnt_nxt = counter_value + 16'h0001;
                end
            end else if (counter_value == `CIC_BOTTOM) begin
                dir_nxt = 1'b0; // turn at bottom, overflow here
                cnt_nxt = counter_value + 16'h0001;
                ovf_hit = 1'b1;
            end else begin
                cnt_nxt = counter_value - 16'h0001;
            end
        end else if (mode_wrap_top && counter_value == top_value) begin
            cnt_nxt = `CIC_BOTTOM; // fast modes overflow at top
            ovf_hit = 1'b1;
        end else if (mode_clear_top && counter_value == top_value) begin
            cnt_nxt = `CIC_BOTTOM;
        end else begin
            cnt_nxt = counter_value + 16'h0001;
            ovf_hit = (counter_value == `CIC_MAX); // normal and clear modes overflow at max
        end
    end

    // counter register; cpu write wins over counting
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            counter_value <= `CIC_RST_WORD;
            dir_down_r <= 1'b0;
        end else if (wr_cnt_lo) begin
            counter_value <= {temp_r, io_wdata};
        end else if (timer_tick) begin
            counter_value <= cnt_nxt;
            dir_down_r <= dir_nxt;
        end
    end

    // =====
    // capture register
    // every qualified edge overwrites, read or not
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            capture_value <= `CIC_RST_WORD;
        end else if (wr_cap_lo) begin
            capture_value <= {temp_r, io_wdata};
        end else if (capture_event) begin
            capture_value <= counter_value;
        end
    end

    // =====
    // shared high-byte latch
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            temp_r <= `CIC_RST_BYTE;
        end else if (wr_any_hi) begin
            temp_r <= io_wdata; // high write only fills latch
        end else if (io_rd && !io_wr && io_addr == `CIC_A_CNT_LO) begin
            temp_r <= counter_value[15:8];
        end else if (io_rd && !io_wr && io_addr == `CIC_A_CAP_LO) begin
            temp_r <= capture_value[15:8];
        end
    end

    // =====
    // plain control registers and compare a
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            control_reg_a <= `CIC_RST_BYTE;
            control_reg_b <= `CIC_RST_BYTE;
            comparator_ctrl_status <= `CIC_RST_BYTE;
            compare_a_value <= `CIC_RST_WORD;
            overflow_irq_enable <= 1'b0;
            capture_irq_enable <= 1'b0;
        end else if (io_wr) begin
            case (io_addr)
                `CIC_A_CTRL_A: control_reg_a <= io_wdata;
                `CIC_A_CTRL_B: control_reg_b <= io_wdata;
                `CIC_A_COMP: comparator_ctrl_status <= io_wdata;
                `CIC_A_CMPA_LO: compare_a_value <= {temp_r, io_wdata};
                `CIC_A_MASK: begin
                    overflow_irq_enable <= io_wdata[`CIC_F_OVF];
                    capture_irq_enable <= io_wdata[`CIC_F_CAP];
                end
                default: begin
                    control_reg_a <= control_reg_a; // others handled elsewhere
                end
            endcase
        end
    end

    // =====
    // sticky flags: set beats clear in the same cycle
    wire clr_write; // write to flag location
    assign clr_write = io_wr && (io_addr == `CIC_A_FLAGS);

    // flag set with the capture copy, cleared by service or one
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            capture_flag <= 1'b0;
            overflow_flag <= 1'b0;
        end else begin
            if (capture_event) begin
                capture_flag <= 1'b1;
            end else if (irq_ack_capture || (clr_write && io_wdata[`CIC_F_CAP])) begin
                capture_flag <= 1'b0;
            end
            if (timer_tick && !wr_cnt_lo && ovf_hit) begin
                overflow_flag <= 1'b1;
            end else if (irq_ack_overflow || (clr_write && io_wdata[`CIC_F_OVF])) begin
                overflow_flag <= 1'b0;
            end
        end
    end

    // requests gated by their enables
    assign irq_capture = capture_flag && capture_irq_enable;
    assign irq_overflow = overflow_flag && overflow_irq_enable;

    // =====
    // read data, registered
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            io_rdata <= `CIC_RST_BYTE;
        end else if (io_rd) begin
            case (io_addr)
                `CIC_A_CTRL_A: io_rdata <= control_reg_a;
                `CIC_A_CTRL_B: io_rdata <= control_reg_b;
                `CIC_A_CNT_LO: io_rdata <= counter_value[7:0];
                `CIC_A_CNT_HI: io_rdata <= temp_r;
                `CIC_A_CAP_LO: io_rdata <= capture_value[7:0];
                `CIC_A_CAP_HI: io_rdata <= temp_r;
                `CIC_A_CMPA_LO: io_rdata <= compare_a_value[7:0];
                `CIC_A_CMPA_HI: io_rdata <= compare_a_value[15:8];
                `CIC_A_FLAGS: begin
                    io_rdata <= `CIC_RST_BYTE;
                    io_rdata[`CIC_F_OVF] <= overflow_flag;
                    io_rdata[`CIC_F_CAP] <= capture_flag;
                end
                `CIC_A_MASK: begin
                    io_rdata <= `CIC_RST_BYTE;
                    io_rdata[`CIC_F_OVF] <= overflow_irq_enable;
                    io_rdata[`CIC_F_CAP] <= capture_irq_enable;
                end
                `CIC_A_COMP: io_rdata <= comparator_ctrl_status;
                default: io_rdata <= `CIC_RST_BYTE; // unmapped reads zero
            endcase
        end
    end

endmodule
`default_nettype wire

// file: verif/cic_event_src.sv
// event source at the capture pin and the comparator output
// assumes: levels change just after a falling clock edge
`default_nettype none
module cic_event_src (
    input wire logic clk, // system clock
    output var logic capture_pin, // capture pin level
    output var logic comparator_output // comparator level
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        capture_pin = 1'b0;
        comparator_output = 1'b0;
    end
    // set one level and hold it; the pin may be our own port drive
    task automatic drive(input logic v, input int hold, input logic sel = 1'b0);
        @(negedge clk);
        if (sel) begin
            comparator_output = v;
        end else begin
            capture_pin = v;
        end
        repeat (hold) @(negedge clk);
    endtask
endmodule
`default_nettype wire

// file: verif/cic_timer_assertions.sv
// port checker for the capture timer
// assumes: bound to cic_timer; control bytes are shadowed from bus writes
`include "cic_defines.vh"
`default_nettype none
module cic_timer_checker (
    input wire logic clk, // system clock
    input wire logic reset, // async reset
    input wire logic [3:0] io_addr, // location
    input wire logic io_wr, // write strobe
    input wire logic io_rd, // read strobe
    input wire logic [7:0] io_wdata, // write data
    input wire logic [7:0] io_rdata, // read data
    input wire logic prescale_tick, // timer tick
    input wire logic capture_pin, // pin level
    input wire logic comparator_output, // comparator level
    input wire logic irq_ack_capture, // capture serviced
    input wire logic irq_ack_overflow, // overflow serviced
    input wire logic irq_capture, // capture request
    input wire logic irq_overflow, // overflow request
    input wire logic [15:0] counter_value // live count
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] cta_r; // mode low bits
    logic [7:0] ctb_r; // control b copy
    logic [7:0] en_r; // enable copy
    logic src_r; // comparator chosen
    logic pin_d_r; // last pin level
    logic cmp_d_r; // last comparator level
    logic [3:0] quiet_r; // cycles since a trigger change
    logic [7:0] hi_r; // last high byte written
    logic hi_ok_r; // latch still holds hi_r
    logic [3:0] mode; // waveform mode
    logic cap_top; // capture register is top
    logic cnt_wr; // counter low write
    assign mode = {ctb_r[4:3], cta_r};
    assign cap_top = mode[3] & ~mode[0];
    assign cnt_wr = io_wr & (io_addr == `CIC_A_CNT_LO);

    // =====
    // shadow registers
    // copies of bus writes
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cta_r <= 2'h0;
            ctb_r <= 8'h00;
            en_r <= 8'h00;
            src_r <= 1'b0;
            pin_d_r <= 1'b0;
            cmp_d_r <= 1'b0;
            quiet_r <= 4'h0;
            hi_r <= 8'h00;
            hi_ok_r <= 1'b0;
        end else begin
            if (io_wr && io_addr == `CIC_A_CTRL_A) cta_r <= io_wdata[1:0];
            if (io_wr && io_addr == `CIC_A_CTRL_B) ctb_r <= io_wdata;
            if (io_wr && io_addr == `CIC_A_MASK) en_r <= io_wdata;
            if (io_wr && io_addr == `CIC_A_COMP) src_r <= io_wdata[`CIC_C_SRC];
            pin_d_r <= capture_pin;
            cmp_d_r <= comparator_output;
            // a trigger change restarts the quiet count
            if (capture_pin != pin_d_r || comparator_output != cmp_d_r) begin
                quiet_r <= 4'h0;
            end else if (quiet_r != 4'hF) begin
                quiet_r <= quiet_r + 4'h1;
            end
            // high writes fill the latch, low reads overwrite it
            if (io_wr && (io_addr == `CIC_A_CNT_HI || io_addr == `CIC_A_CAP_HI || io_addr == `CIC_A_CMPA_HI)) begin
                hi_r <= io_wdata;
                hi_ok_r <= 1'b1;
            end else if (io_rd && (io_addr == `CIC_A_CNT_LO || io_addr == `CIC_A_CAP_LO)) begin
                hi_ok_r <= 1'b0;
            end
        end
    end

    // =====
    // assertions
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    a_stop_holds: assert property (ctb_r[2:0] == 3'h0 && !cnt_wr |=> $stable(counter_value))
        else $error("counter moved while stopped");
    a_write_loads: assert property (cnt_wr && hi_ok_r |=> counter_value == {$past(hi_r), $past(io_wdata)})
        else $error("counter write did not load latch and low byte");
    a_count_up: assert property (mode == 4'h0 && ctb_r[2:0] != 3'h0 && prescale_tick && !cnt_wr
        |=> counter_value == $past(counter_value) + 16'h0001) else $error("normal mode did not step up");
    a_ovf_at_max: assert property (mode == 4'h0 && ctb_r[2:0] != 3'h0 && prescale_tick && !cnt_wr
        && en_r[`CIC_F_OVF] && counter_value == 16'hFFFF |=> irq_overflow) else $error("no overflow at max");
    a_read_low: assert property (io_rd && !io_wr && io_addr == `CIC_A_CNT_LO
        |=> io_rdata == $past(counter_value[7:0])) else $error("low byte read wrong");
    a_read_high: assert property (io_rd && !io_wr && io_addr == `CIC_A_CNT_LO ##2 io_rd && !io_wr
        && io_addr == `CIC_A_CNT_HI |=> io_rdata == $past(counter_value[15:8], 3)) else $error("latch read wrong");
    a_capture_plain: assert property (!ctb_r[7] && ctb_r[6] && !src_r && !cap_top && en_r[5] && !irq_capture
        && $rose(capture_pin) ##1 capture_pin [*3] |-> !irq_capture ##1 irq_capture)
        else $error("capture flag timing wrong without filter");
    a_capture_filtered: assert property (ctb_r[7] && ctb_r[6] && !src_r && !cap_top && en_r[5] && !irq_capture
        && $rose(capture_pin) ##1 capture_pin [*7] |-> !irq_capture ##1 irq_capture)
        else $error("capture flag timing wrong with filter");
    a_top_blocks: assert property (cap_top |=> !$rose(irq_capture))
        else $error("capture while capture register is top");
    a_flag_clears: assert property ((irq_ack_capture || (io_wr && io_addr == `CIC_A_FLAGS && io_wdata[5]))
        && quiet_r == 4'hF |=> !irq_capture) else $error("capture flag not cleared");
endmodule

bind cic_timer cic_timer_checker chk (.*);
`default_nettype wire

// file: verif/cic_timer_bench.sv
// self-checking bench for the capture timer
// assumes: design files under logic/, checker bound, event source model
`include "cic_defines.vh"
`default_nettype none
module cic_timer_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, reset, io_wr, io_rd, prescale_tick, irq_ack_capture, irq_ack_overflow;
    logic [3:0] io_addr; // location
    logic [7:0] io_wdata; // write data
    wire [7:0] io_rdata; // read data
    wire [15:0] counter_value; // live count
    wire capture_pin, comparator_output, irq_capture, irq_overflow;
    int err_count = 0;
    int tests_run = 0;

    cic_timer uut (.clk(clk), .reset(reset), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
        .io_rdata(io_rdata), .prescale_tick(prescale_tick), .capture_pin(capture_pin),
        .comparator_output(comparator_output), .irq_ack_capture(irq_ack_capture),
        .irq_ack_overflow(irq_ack_overflow), .irq_capture(irq_capture), .irq_overflow(irq_overflow),
        .counter_value(counter_value));
    cic_event_src ev (.clk(clk), .capture_pin(capture_pin), .comparator_output(comparator_output));

    // =====
    // clock, watchdog and bus tasks
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // a hang counts as a mismatch
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        give_verdict();
    end
    // one write, optionally with a tick in the same cycle
    task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic tk = 1'b0);
        @(negedge clk);
        io_addr = a;
        io_wdata = d;
        io_wr = 1'b1;
        prescale_tick = tk;
        @(negedge clk);
        io_wr = 1'b0;
        prescale_tick = 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(negedge clk);
        io_addr = a;
        io_rd = 1'b1;
        @(negedge clk);
        io_rd = 1'b0;
        d = io_rdata;
    endtask
    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: word %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: request %b expected %b", $time, got, exp);
        end
    endtask
    // low byte first, then the latch
    task automatic rd_chk(input logic [3:0] lo, input logic [15:0] exp);
        logic [7:0] lb, hb;
        rd(lo, lb);
        rd(lo + 4'h1, hb);
        chk_word({hb, lb}, exp);
    endtask
    task automatic ticks(input int n);
        repeat (n) begin
            @(negedge clk);
            prescale_tick = 1'b1;
            @(negedge clk);
            prescale_tick = 1'b0;
        end
    endtask
    // bounded wait for the capture request
    task automatic wait_cap(input logic exp);
        for (int i = 0; i < 30 && !irq_capture; i++) @(negedge clk);
        chk_bit(irq_capture, exp);
    endtask
    task automatic end_test(input string name);
        $display("test %s done, mismatches so far %0d", name, err_count);
    endtask
    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // =====
    // main sequence
    initial begin
        logic [7:0] b;
        reset = 1'b1;
        {io_wr, io_rd, prescale_tick, irq_ack_capture, irq_ack_overflow} = 5'h00;
        io_addr = 4'h0;
        io_wdata = 8'h00;
        repeat (20) @(negedge clk);
        reset = 1'b0;
        rd_chk(`CIC_A_CNT_LO, 16'h0000);
        rd(4'hF, b);
        chk_word({8'h00, b}, 16'h0000);
        end_test("reset");
        wr(`CIC_A_CNT_HI, 8'h01, 1'b1);
        wr(`CIC_A_CNT_LO, 8'hFF, 1'b1);
        ticks(3);
        rd_chk(`CIC_A_CNT_LO, 16'h01FF);
        wr(`CIC_A_CTRL_B, 8'h01);
        ticks(3);
        rd_chk(`CIC_A_CNT_LO, 16'h0202);
        wr(`CIC_A_CNT_HI, 8'h12);
        wr(`CIC_A_CNT_LO, 8'h34, 1'b1);
        rd_chk(`CIC_A_CNT_LO, 16'h1234);
        wr(`CIC_A_MASK, 8'h21);
        wr(`CIC_A_CNT_HI, 8'hFF);
        wr(`CIC_A_CNT_LO, 8'hFF);
        ticks(1);
        chk_bit(irq_overflow, 1'b1);
        rd_chk(`CIC_A_CNT_LO, 16'h0000);
        @(negedge clk) irq_ack_overflow = 1'b1;
        @(negedge clk) irq_ack_overflow = 1'b0;
        chk_bit(irq_overflow, 1'b0);
        end_test("counter");
        wr(`CIC_A_CTRL_B, 8'h40);
        wr(`CIC_A_CNT_HI, 8'hAB);
        wr(`CIC_A_CNT_LO, 8'hCD);
        ev.drive(1'b1, 1);
        wait_cap(1'b1);
        rd_chk(`CIC_A_CAP_LO, 16'hABCD);
        wr(`CIC_A_FLAGS, 8'h20);
        chk_bit(irq_capture, 1'b0);
        wr(`CIC_A_CNT_HI, 8'h13);
        wr(`CIC_A_CNT_LO, 8'h57);
        ev.drive(1'b0, 1);
        wait_cap(1'b0);
        wr(`CIC_A_CTRL_B, 8'h00);
        ev.drive(1'b1, 1);
        wait_cap(1'b0);
        ev.drive(1'b0, 1);
        wait_cap(1'b1);
        wr(`CIC_A_CNT_HI, 8'h22);
        wr(`CIC_A_CNT_LO, 8'h22);
        wr(`CIC_A_CTRL_B, 8'h40);
        wr(`CIC_A_FLAGS, 8'h20);
        ev.drive(1'b1, 1);
        wait_cap(1'b1);
        rd_chk(`CIC_A_CAP_LO, 16'h2222);
        @(negedge clk) irq_ack_capture = 1'b1;
        @(negedge clk) irq_ack_capture = 1'b0;
        chk_bit(irq_capture, 1'b0);
        end_test("capture");
        wr(`CIC_A_CTRL_B, 8'hC0);
        ev.drive(1'b0, 12);
        ev.drive(1'b1, 1);
        ev.drive(1'b0, 12);
        wait_cap(1'b0);
        ev.drive(1'b1, 1);
        wait_cap(1'b1);
        wr(`CIC_A_FLAGS, 8'h20);
        wr(`CIC_A_CTRL_B, 8'h40);
        wr(`CIC_A_COMP, 8'h04);
        repeat (15) @(negedge clk);
        wr(`CIC_A_FLAGS, 8'h20);
        ev.drive(1'b1, 1, 1'b1);
        wait_cap(1'b1);
        wr(`CIC_A_FLAGS, 8'h20);
        ev.drive(1'b0, 1);
        ev.drive(1'b1, 1);
        wait_cap(1'b0);
        wr(`CIC_A_COMP, 8'h00);
        repeat (15) @(negedge clk);
        wr(`CIC_A_FLAGS, 8'h20);
        end_test("source");
        wr(`CIC_A_CTRL_A, 8'h02);
        wr(`CIC_A_CTRL_B, 8'h58);
        wr(`CIC_A_CAP_HI, 8'h24);
        wr(`CIC_A_CAP_LO, 8'h68);
        ev.drive(1'b0, 1);
        ev.drive(1'b1, 1);
        wait_cap(1'b0);
        rd_chk(`CIC_A_CAP_LO, 16'h2468);
        wr(`CIC_A_CTRL_A, 8'h00);
        wr(`CIC_A_CTRL_B, 8'h40);
        wr(`CIC_A_CAP_HI, 8'h11);
        wr(`CIC_A_CAP_LO, 8'h11);
        rd_chk(`CIC_A_CAP_LO, 16'h2468);
        end_test("top");
        give_verdict();
    end
endmodule
`default_nettype wire
